// >>> sim/sensor_model.sv
// Sensor front end: per-channel measured values and loop currents.
// Assumes writes from the bench on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module sensor_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic setStb,
  input wire logic [2:0] setCh,
  input wire logic [15:0] setVal,
  input wire logic [7:0] overCur,
  output logic [127:0] measValue,
  output logic [127:0] loopCurrentUa
);
  logic [15:0] val_q [8];
  // Hold the last value written to each channel
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      val_q <= '{default: 16'h0064};
    end
    else if (setStb)
    begin
      val_q[setCh] <= setVal;
    end
  end
  // Pack values; a faulty loop reads above full scale
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      measValue[16*i+:16] = val_q[i];
      loopCurrentUa[16*i+:16] = overCur[i] ? 16'h5000 : 16'h2EE0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_threshold_alarm_monitor.sv
// Self-checking bench for the threshold and alarm monitor.
// Assumes a 5 ns clock and a ten-cycle second for speed.
`timescale 1ns/100ps
`default_nettype none
module tb_threshold_alarm_monitor;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic loggerRun = 1'b1;
  logic powersaveCmd = 1'b0;
  logic latchMode = 1'b1;
  logic defrostCheck = 1'b0;
  logic hostAck = 1'b0;
  logic batteryChangeCmd = 1'b0;
  logic monitorUpdate = 1'b0;
  logic extSupplyPin = 1'b1;
  logic keyWakePin = 1'b0;
  logic keyAckPin = 1'b0;
  logic first_digital_input = 1'b0;
  logic second_digital_input = 1'b0;
  logic setStb = 1'b0;
  logic [2:0] setCh = 3'h0;
  logic [15:0] setVal = 16'h0000;
  logic [7:0] overCur = 8'h00;
  logic [15:0] logIntervalSec = 16'h0004;
  logic [7:0] channelSelect = 8'hFF;
  logic [7:0] alarmEnable = 8'hF7;
  logic [15:0] alarmDelaySec = 16'h0006;
  logic [15:0] defrostDelaySec = 16'h0002;
  logic [127:0] upperLimit = {8{16'h00C8}};
  logic [127:0] lowerLimit = {8{16'h0032}};
  logic [31:0] capacityLimit = 32'h00000005;
  logic [127:0] measValue, loopCurrentUa;
  logic alarmContact, mainAlarm, powersave_alarm_tag, displayOn, recordCircles;
  logic powersaveActive, batteryLow, protoValid, logStore;
  logic [7:0] sensorAlarm, arrowAbove, arrowBelow, overflowFlag, underflowFlag, logAlarmMask;
  logic [1:0] protoCode, marker_position, forwardedAlarm;
  logic [2:0] protoChannel;
  logic [3:0] watch;
  logic [2:0] alarmCh = 3'h0;
  int errors = 0;
  int totalChecks = 0;
  int evCnt [4] = '{0, 0, 0, 0};
  int n;

  threshold_alarm_monitor #(.TICKS_PER_SEC(10)) u_threshold_alarm_monitor (.sys_clk, .rst,
    .loggerRun, .powersaveCmd, .logIntervalSec, .channelSelect, .alarmEnable, .latchMode,
    .defrostCheck, .alarmDelaySec, .defrostDelaySec, .measValue, .upperLimit, .lowerLimit,
    .loopCurrentUa, .hostAck, .batteryChangeCmd, .capacityLimit, .monitorUpdate,
    .extSupplyPin, .keyWakePin, .keyAckPin, .first_digital_input, .second_digital_input,
    .alarmContact, .mainAlarm, .powersave_alarm_tag, .sensorAlarm, .arrowAbove, .arrowBelow,
    .overflowFlag, .underflowFlag, .displayOn, .recordCircles, .powersaveActive, .batteryLow,
    .protoValid, .protoCode, .protoChannel, .logStore, .logAlarmMask, .marker_position,
    .forwardedAlarm);
  sensor_model u_sensor_model (.sys_clk, .rst, .setStb, .setCh, .setVal, .overCur,
    .measValue, .loopCurrentUa);

  // Clock and watched flags
  always #2.5 sys_clk = ~sys_clk;
  assign watch = {overflowFlag[0], arrowAbove[0], logStore, mainAlarm};
  // Count protocol events by code, off the launching edge
  always @(negedge sys_clk)
  begin
    if (protoValid === 1'b1)
    begin
      evCnt[protoCode]++;
      if (protoCode == 2'h2)
      begin
        alarmCh = protoChannel;
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic wait_bit(input int which, input logic lvl);
    n = 0;
    while (watch[which] !== lvl && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    // A wait that runs out is a mismatch, never a silent pass
    if (watch[which] !== lvl)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, watch[which], lvl);
    end
  endtask

  task automatic set_val(input int ch, input logic [15:0] v);
    @(posedge sys_clk);
    setStb <= 1'b1;
    setCh <= 3'(ch);
    setVal <= v;
    @(posedge sys_clk);
    setStb <= 1'b0;
  endtask

  task automatic ack_host();
    hostAck <= 1'b1;
    @(posedge sys_clk);
    hostAck <= 1'b0;
    cyc(5);
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial
  begin
    cyc(4);
    rst <= 1'b0;
    cyc(12);
    check(mainAlarm, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      set_val(0, 16'h00C9);
      wait_bit(2, 1'b1);
      check(arrowAbove, 8'h01);
      set_val(0, 16'h0064);
      wait_bit(2, 1'b0);
      check(n > 30 && n < 43, 1'b1);
      check(mainAlarm, 1'b0);
    end
    check(evCnt[0], 2);
    set_val(2, 16'h0031);
    wait_bit(0, 1'b1);
    check(sensorAlarm, 8'h04);
    check(alarmContact, 1'b1);
    wait_bit(1, 1'b1);
    check(logAlarmMask, 8'h04);
    check(evCnt[2], 1);
    check(alarmCh, 3'h2);
    set_val(2, 16'h0064);
    cyc(90);
    check(arrowBelow, 8'h00);
    check(mainAlarm, 1'b1);
    ack_host();
    check(mainAlarm, 1'b0);
    check(evCnt[3], 1);
    latchMode <= 1'b0;
    set_val(1, 16'h00FF);
    wait_bit(0, 1'b1);
    check(sensorAlarm, 8'h02);
    set_val(1, 16'h0064);
    wait_bit(0, 1'b0);
    cyc(5);
    check(evCnt[3], 2);
    set_val(3, 16'h00FF);
    cyc(90);
    check(arrowAbove, 8'h00);
    check(sensorAlarm, 8'h00);
    defrostCheck <= 1'b1;
    first_digital_input <= 1'b1;
    latchMode <= 1'b1;
    cyc(10);
    check(marker_position, 2'h1);
    set_val(0, 16'h00C9);
    wait_bit(2, 1'b1);
    set_val(0, 16'h0064);
    wait_bit(0, 1'b1);
    check(sensorAlarm, 8'h01);
    keyAckPin <= 1'b1;
    cyc(8);
    keyAckPin <= 1'b0;
    cyc(8);
    check(mainAlarm, 1'b0);
    defrostCheck <= 1'b0; // Input one now used for markers and forwarding only
    powersaveCmd <= 1'b1;
    cyc(10);
    check(powersaveActive, 1'b1);
    check({displayOn, recordCircles}, 2'h1);
    set_val(0, 16'h0020);
    wait_bit(0, 1'b1);
    check(powersave_alarm_tag, 1'b1);
    set_val(0, 16'h0064);
    ack_host();
    powersaveCmd <= 1'b0;
    cyc(45);
    extSupplyPin <= 1'b0;
    cyc(10);
    check({powersaveActive, displayOn}, 2'h2);
    keyWakePin <= 1'b1;
    cyc(8);
    check(displayOn, 1'b1);
    keyWakePin <= 1'b0;
    cyc(60);
    check(batteryLow, 1'b1);
    batteryChangeCmd <= 1'b1; // Energy count restarts after a new battery
    @(posedge sys_clk);
    batteryChangeCmd <= 1'b0;
    cyc(3);
    check(batteryLow, 1'b0);
    extSupplyPin <= 1'b1;
    second_digital_input <= 1'b1;
    cyc(10);
    monitorUpdate <= 1'b1;
    @(posedge sys_clk);
    monitorUpdate <= 1'b0;
    cyc(3);
    check(forwardedAlarm, 2'h3);
    check(alarmContact, 1'b0);
    first_digital_input <= 1'b0;
    second_digital_input <= 1'b0;
    cyc(10);
    check({forwardedAlarm, marker_position}, 4'hC);
    overCur <= 8'h01;
    wait_bit(3, 1'b1);
    check(overflowFlag, 8'h01);
    check(underflowFlag, 8'h00);
    set_val(0, 16'h00FF);
    wait_bit(2, 1'b1);
    loggerRun <= 1'b0;
    cyc(5);
    check({arrowAbove, overflowFlag}, 16'h0000);
    cyc(90);
    check(mainAlarm, 1'b0);
    close_out();
  end

  // Cut a hung run short
  initial
  begin
    #40000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> sim/threshold_alarm_monitor_asserts.sv
// Port-level checker for the threshold and alarm monitor.
// Assumes sys_clk with an asynchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
`include "alarm_defines.svh"
module threshold_alarm_monitor_asserts
  import alarm_pkg::*;
#(
  parameter int NCH = 8
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic loggerRun,
  input wire logic batteryChangeCmd,
  input wire logic [31:0] capacityLimit,
  input wire logic monitorUpdate,
  input wire logic alarmContact,
  input wire logic mainAlarm,
  input wire logic powersave_alarm_tag,
  input wire logic [NCH-1:0] sensorAlarm,
  input wire logic [NCH-1:0] arrowAbove,
  input wire logic [NCH-1:0] arrowBelow,
  input wire logic recordCircles,
  input wire logic powersaveActive,
  input wire logic batteryLow,
  input wire logic protoValid,
  input wire logic [1:0] protoCode,
  input wire logic logStore,
  input wire logic [NCH-1:0] logAlarmMask,
  input wire logic [1:0] forwardedAlarm
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Alarm edges and their protocol entries
  sequence s_alarm_up;
    $rose(mainAlarm);
  endsequence
  sequence s_on_logged;
    ##[0:40] (protoValid && protoCode == `EVT_ALARM_ON);
  endsequence
  sequence s_alarm_down;
    $fell(mainAlarm);
  endsequence
  sequence s_off_logged;
    ##[0:40] (protoValid && protoCode == `EVT_ALARM_OFF);
  endsequence

  a_alarm_on_logged: assert property (s_alarm_up |-> s_on_logged)
    else $error("alarm rise without protocol entry");
  a_alarm_off_logged: assert property (s_alarm_down |-> s_off_logged)
    else $error("alarm fall without protocol entry");
  a_stop_clears: assert property (!loggerRun [*4] |->
    !mainAlarm && arrowAbove == '0 && arrowBelow == '0)
    else $error("indication while stopped");
  a_contact_main: assert property (alarmContact == mainAlarm)
    else $error("contact and display differ");
  a_contact_or: assert property (alarmContact == |sensorAlarm)
    else $error("contact is not the channel alarm OR");
  a_tag_psave: assert property (powersave_alarm_tag |-> mainAlarm)
    else $error("power-save tag without alarm");
  a_circles_psave: assert property (recordCircles |->
    powersaveActive || $past(powersaveActive))
    else $error("circles outside power-save");
  a_logmask_idle: assert property (!logStore |-> logAlarmMask == '0)
    else $error("log mask outside store");
  a_batt_clear: assert property (batteryChangeCmd && capacityLimit > 32'h2
    |-> ##[1:3] !batteryLow)
    else $error("battery low not cleared");
  a_fwd_hold: assert property (!$past(monitorUpdate) |-> $stable(forwardedAlarm))
    else $error("forwarded inputs changed between updates");
endmodule

bind threshold_alarm_monitor threshold_alarm_monitor_asserts #(.NCH(NCH))
  u_threshold_alarm_monitor_asserts (.sys_clk, .rst, .loggerRun, .batteryChangeCmd,
  .capacityLimit, .monitorUpdate, .alarmContact, .mainAlarm, .powersave_alarm_tag,
  .sensorAlarm, .arrowAbove, .arrowBelow, .recordCircles, .powersaveActive,
  .batteryLow, .protoValid, .protoCode, .logStore, .logAlarmMask, .forwardedAlarm);
`default_nettype wire

// >>> verilog/alarm_defines.svh
// Constants for the eight-channel threshold and alarm monitor.
// Assumes a 200 MHz system clock; times are in seconds or cycles.
//
// Function
// - Normal mode checks every 4 s, or each log interval if shorter.
// - Power-save checks once a minute, or each log interval if shorter.
// - Alarm in power-save shows main alarm plus power-save alarm tag.
// - Stopped logger does no checking and shows no violation or alarm.
// - Above/below arrows lit only while violation persists; never logged.
// - Alarm shown once conditions met; latching set by output configuration.
// - Collective alarm output switches in the same cycle as alarm display.
// - Expired alarm stored in memory only after next log interval ends.
// - Every violation and alarm, however short, goes to the alarm protocol; here only violations present at a check strobe reach it.
// - Host command or keypad acknowledges alarms; device clears them.
// - Delay timer restarts at each new violation; short ones never alarm.
// - Long violation operates contact at expiry; protocol gets on and off.
// - Power-save blanks display; four circles show correct recording.
// - Missing external supply forces power-save; keypad wakes display briefly.
// - Host configuration command switches power-save on and off.
// - Energy counter tracks battery use; battery-low lit at capacity limit.
// - Digital inputs never reach protocol or contacts; only table markers, forwarded alarms and, for the first input, defrost delay selection.
// - Forwarded input alarms sampled only at monitoring software updates.
// - Violation is above upper or below lower, until back in band.
// - Defrost check enabled and first input closed selects defrost delay.
// - Loop current above upper fault level overflow, below lower underflow.
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

`define CLK_HZ 200000000
`define SEC_CYCLES (`CLK_HZ * 1)
`define CHECK_NORMAL_S 16'h0004
`define CHECK_PSAVE_S 16'h003C
`define DISPLAY_WAKE_S 16'h001E
`define OVERFLOW_UA 16'h4FB0
`define UNDERFLOW_UA 16'h0E10
`define EVT_VIOL_ON 2'h0
`define EVT_VIOL_OFF 2'h1
`define EVT_ALARM_ON 2'h2
`define EVT_ALARM_OFF 2'h3

`endif

// >>> verilog/alarm_pkg.sv
// Types shared by the threshold and alarm monitor.
// Assumes the constants header is included by the modules.
package alarm_pkg;
  typedef enum logic [1:0] {MODE_STOP, MODE_NORMAL, MODE_PSAVE} mode_t;
  typedef logic [1:0] evt_code_t;
endpackage

// >>> verilog/channel_monitor.sv
// Limit comparison, alarm delay and alarm latch for one channel.
// Assumes value and limits on the same clock; strobes are one cycle.
`timescale 1ns/100ps
`default_nettype none
module channel_monitor
  import alarm_pkg::*;
#(
  parameter int VW = 16,
  parameter int DW = 16
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic checkStb,
  input wire logic secTick,
  input wire logic active,
  input wire logic latchMode,
  input wire logic ackStb,
  input wire logic [VW-1:0] value,
  input wire logic [VW-1:0] upper,
  input wire logic [VW-1:0] lower,
  input wire logic [DW-1:0] delaySec,
  output logic above,
  output logic below,
  output logic alarm,
  output logic violRise,
  output logic violFall,
  output logic alarmRise,
  output logic alarmFall
);
  logic [DW-1:0] timer_q;
  logic acked_q;

  // Limit compare and alarm decisions
  wire viol = above | below;
  wire aboveNow = value > upper;
  wire belowNow = value < lower;
  wire newViol = aboveNow | belowNow;
  wire expired = timer_q >= delaySec;
  wire setAlarm = active & viol & ~acked_q & expired & ~alarm;
  wire clrAlarm = alarm & (ackStb | (~latchMode & ~viol));

  // Violation state and delay timer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      above <= 1'b0;
      below <= 1'b0;
      timer_q <= '0;
      violRise <= 1'b0;
      violFall <= 1'b0;
    end
    else if (!active)
    begin
      above <= 1'b0;
      below <= 1'b0;
      timer_q <= '0;
      violRise <= 1'b0;
      violFall <= viol;
    end
    else if (checkStb)
    begin
      above <= aboveNow;
      below <= belowNow;
      violRise <= newViol & ~viol;
      violFall <= viol & ~newViol;
      if (newViol && !viol)
      begin
        timer_q <= '0;
      end
    end
    else
    begin
      violRise <= 1'b0;
      violFall <= 1'b0;
      if (secTick && viol && !expired)
      begin
        timer_q <= timer_q + 1'b1;
      end
    end
  end

  // Alarm latch; a new alarm wins over an acknowledge in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm <= 1'b0;
      acked_q <= 1'b0;
      alarmRise <= 1'b0;
      alarmFall <= 1'b0;
    end
    else
    begin
      alarm <= active & (setAlarm | (alarm & ~clrAlarm));
      acked_q <= active & viol & (acked_q | (ackStb & alarm));
      alarmRise <= setAlarm;
      alarmFall <= alarm & (~active | clrAlarm) & ~setAlarm;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/threshold_alarm_monitor.sv
// Top of the eight-channel threshold and alarm monitor.
// Assumes measured values and host commands on sys_clk; keypad, supply
// sense and digital inputs arrive asynchronously from pins.
`timescale 1ns/100ps
`default_nettype none
`include "alarm_defines.svh"
module threshold_alarm_monitor
  import alarm_pkg::*;
#(
  parameter int NCH = 8,
  parameter int VW = 16,
  parameter int DW = 16,
  parameter int TICKS_PER_SEC = `SEC_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic loggerRun,
  input wire logic powersaveCmd,
  input wire logic [15:0] logIntervalSec,
  input wire logic [NCH-1:0] channelSelect,
  input wire logic [NCH-1:0] alarmEnable,
  input wire logic latchMode,
  input wire logic defrostCheck,
  input wire logic [DW-1:0] alarmDelaySec,
  input wire logic [DW-1:0] defrostDelaySec,
  input wire logic [NCH*VW-1:0] measValue,
  input wire logic [NCH*VW-1:0] upperLimit,
  input wire logic [NCH*VW-1:0] lowerLimit,
  input wire logic [NCH*16-1:0] loopCurrentUa,
  input wire logic hostAck,
  input wire logic batteryChangeCmd,
  input wire logic [31:0] capacityLimit,
  input wire logic monitorUpdate,
  input wire logic extSupplyPin,
  input wire logic keyWakePin,
  input wire logic keyAckPin,
  input wire logic first_digital_input,
  input wire logic second_digital_input,
  output logic alarmContact,
  output logic mainAlarm,
  output logic powersave_alarm_tag,
  output logic [NCH-1:0] sensorAlarm,
  output logic [NCH-1:0] arrowAbove,
  output logic [NCH-1:0] arrowBelow,
  output logic [NCH-1:0] overflowFlag,
  output logic [NCH-1:0] underflowFlag,
  output logic displayOn,
  output logic recordCircles,
  output logic powersaveActive,
  output logic batteryLow,
  output logic protoValid,
  output logic [1:0] protoCode,
  output logic [2:0] protoChannel,
  output logic logStore,
  output logic [NCH-1:0] logAlarmMask,
  output logic [1:0] marker_position,
  output logic [1:0] forwardedAlarm
);
  localparam int NPIN = 5;
  localparam int NEV = 4 * NCH;

  generate
    if (NCH < 1 || NCH > 8 || VW < 1 || DW < 1)
    begin : g_chk
      $error("threshold_alarm_monitor supports one to eight channels");
    end
  endgenerate

  // Pin synchroniser: three stages, accept when the last two agree
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync3_q;
  logic [NPIN-1:0] pinFilt_q;
  wire [NPIN-1:0] pinRaw = {keyAckPin, keyWakePin, extSupplyPin,
                            second_digital_input, first_digital_input};
  wire [NPIN-1:0] pinAgree = ~(sync2_q ^ sync3_q);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pinFilt_q <= '0;
    end
    else
    begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pinFilt_q <= (pinAgree & sync3_q) | (~pinAgree & pinFilt_q);
    end
  end

  wire din1 = pinFilt_q[0];
  wire din2 = pinFilt_q[1];
  wire supplyOk = pinFilt_q[2];
  wire keyWake = pinFilt_q[3];
  wire keyAck = pinFilt_q[4];

  // Keypad edges
  logic keyWakePrev_q;
  logic keyAckPrev_q;
  wire keyWakeStb = keyWake & ~keyWakePrev_q;
  wire keyAckStb = keyAck & ~keyAckPrev_q;
  wire ackStb = hostAck | keyAckStb;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      keyWakePrev_q <= 1'b0;
      keyAckPrev_q <= 1'b0;
    end
    else
    begin
      keyWakePrev_q <= keyWake;
      keyAckPrev_q <= keyAck;
    end
  end

  // One-second enable
  logic secTick;

  tick_divider #(
    .DIV(TICKS_PER_SEC)
  ) u_sec (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(secTick)
  );

  // Operating mode and check period
  wire psave = powersaveCmd | ~supplyOk;
  wire [15:0] logInt = (logIntervalSec == 16'h0000) ? 16'h0001 : logIntervalSec;
  mode_t mode;
  logic [15:0] checkPeriod;

  assign mode = !loggerRun ? MODE_STOP : (psave ? MODE_PSAVE : MODE_NORMAL);

  always_comb
  begin
    unique case (mode)
      MODE_STOP: checkPeriod = 16'h0001;
      MODE_NORMAL: checkPeriod = (logInt < `CHECK_NORMAL_S) ? logInt : `CHECK_NORMAL_S;
      MODE_PSAVE: checkPeriod = (logInt > `CHECK_PSAVE_S) ? `CHECK_PSAVE_S : logInt;
    endcase
  end

  // Check and log interval counters in seconds
  logic [15:0] checkCount_q;
  logic [15:0] logCount_q;
  logic checkStb_q;
  logic logTick_q;
  wire checkDue = secTick & (checkCount_q + 16'h0001 >= checkPeriod);
  wire logDue = secTick & (logCount_q + 16'h0001 >= logInt);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      checkCount_q <= 16'h0000;
      logCount_q <= 16'h0000;
      checkStb_q <= 1'b0;
      logTick_q <= 1'b0;
    end
    else if (mode == MODE_STOP)
    begin
      checkCount_q <= 16'h0000;
      logCount_q <= 16'h0000;
      checkStb_q <= 1'b0;
      logTick_q <= 1'b0;
    end
    else
    begin
      checkStb_q <= checkDue;
      logTick_q <= logDue;
      if (secTick)
      begin
        checkCount_q <= checkDue ? 16'h0000 : checkCount_q + 16'h0001;
        logCount_q <= logDue ? 16'h0000 : logCount_q + 16'h0001;
      end
    end
  end

  // Delay selection, defrost overrides the normal delay
  wire [DW-1:0] delaySel = (defrostCheck & din1) ? defrostDelaySec : alarmDelaySec;
  wire [NCH-1:0] chActive = channelSelect & alarmEnable & {NCH{loggerRun}};

  // Per-channel monitors
  logic [NCH-1:0] chAbove;
  logic [NCH-1:0] chBelow;
  logic [NCH-1:0] chAlarm;
  logic [NCH-1:0] evViolOn;
  logic [NCH-1:0] evViolOff;
  logic [NCH-1:0] evAlarmOn;
  logic [NCH-1:0] evAlarmOff;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      channel_monitor #(
        .VW(VW),
        .DW(DW)
      ) u_ch (
        .sys_clk(sys_clk),
        .rst(rst),
        .checkStb(checkStb_q),
        .secTick(secTick),
        .active(chActive[gi]),
        .latchMode(latchMode),
        .ackStb(ackStb),
        .value(measValue[gi*VW +: VW]),
        .upper(upperLimit[gi*VW +: VW]),
        .lower(lowerLimit[gi*VW +: VW]),
        .delaySec(delaySel),
        .above(chAbove[gi]),
        .below(chBelow[gi]),
        .alarm(chAlarm[gi]),
        .violRise(evViolOn[gi]),
        .violFall(evViolOff[gi]),
        .alarmRise(evAlarmOn[gi]),
        .alarmFall(evAlarmOff[gi])
      );
    end
  endgenerate

  // Loop fault levels
  logic [NCH-1:0] ovfNow;
  logic [NCH-1:0] unfNow;

  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_fault
      assign ovfNow[gi] = loopCurrentUa[gi*16 +: 16] > `OVERFLOW_UA;
      assign unfNow[gi] = loopCurrentUa[gi*16 +: 16] < `UNDERFLOW_UA;
    end
  endgenerate

  // Indicators, all registered together so contact and display match
  wire anyAlarm = |chAlarm;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sensorAlarm <= '0;
      arrowAbove <= '0;
      arrowBelow <= '0;
      mainAlarm <= 1'b0;
      alarmContact <= 1'b0;
      powersave_alarm_tag <= 1'b0;
      overflowFlag <= '0;
      underflowFlag <= '0;
    end
    else
    begin
      sensorAlarm <= chAlarm;
      arrowAbove <= chAbove;
      arrowBelow <= chBelow;
      mainAlarm <= anyAlarm;
      alarmContact <= anyAlarm;
      powersave_alarm_tag <= anyAlarm & (mode == MODE_PSAVE);
      if (mode == MODE_STOP)
      begin
        overflowFlag <= '0;
        underflowFlag <= '0;
      end
      else if (checkStb_q)
      begin
        overflowFlag <= ovfNow & channelSelect;
        underflowFlag <= unfNow & channelSelect;
      end
    end
  end

  // Protocol events held pending, served one per cycle, new event wins
  logic [NEV-1:0] pend_q;
  logic [NEV-1:0] served;
  logic [4:0] pick;
  logic pickValid;
  wire [NEV-1:0] newEvt = {evAlarmOff, evAlarmOn, evViolOff, evViolOn};

  always_comb
  begin
    pick = 5'h00;
    pickValid = 1'b0;
    served = '0;
    for (int i = NEV - 1; i >= 0; i--)
    begin
      if (pend_q[i])
      begin
        pick = 5'(i);
        pickValid = 1'b1;
      end
    end
    if (pickValid)
    begin
      served[pick] = 1'b1;
    end
  end

  wire [NCH-1:0] chOfPick = NCH'(pick % NCH);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_q <= '0;
      protoValid <= 1'b0;
      protoCode <= 2'h0;
      protoChannel <= 3'h0;
    end
    else
    begin
      pend_q <= (pend_q & ~served) | newEvt;
      protoValid <= pickValid;
      protoCode <= evt_code_t'(pick / NCH);
      protoChannel <= chOfPick[2:0];
    end
  end

  // Alarms wait for the end of the next log interval before storage
  logic [NCH-1:0] logPend_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      logPend_q <= '0;
      logStore <= 1'b0;
      logAlarmMask <= '0;
    end
    else
    begin
      logStore <= logTick_q & (|logPend_q);
      logAlarmMask <= logTick_q ? logPend_q : '0;
      logPend_q <= (logTick_q ? '0 : logPend_q) | evAlarmOn;
    end
  end

  // Display and power-save behaviour
  logic [15:0] wake_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wake_q <= 16'h0000;
      displayOn <= 1'b0;
      recordCircles <= 1'b0;
      powersaveActive <= 1'b0;
    end
    else
    begin
      if (keyWakeStb)
      begin
        wake_q <= `DISPLAY_WAKE_S;
      end
      else if (secTick && wake_q != 16'h0000)
      begin
        wake_q <= wake_q - 16'h0001;
      end
      displayOn <= ~psave | (wake_q != 16'h0000);
      recordCircles <= psave & loggerRun;
      powersaveActive <= psave;
    end
  end

  // Battery energy counter, cleared by the battery change command
  logic [31:0] energy_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      energy_q <= 32'h0000_0000;
      batteryLow <= 1'b0;
    end
    else
    begin
      if (batteryChangeCmd)
      begin
        energy_q <= 32'h0000_0000;
      end
      else if (secTick && !supplyOk && energy_q != 32'hFFFF_FFFF)
      begin
        energy_q <= energy_q + 32'h0000_0001;
      end
      batteryLow <= ~batteryChangeCmd & (energy_q >= capacityLimit);
    end
  end

  // Digital inputs: table markers and forwarded alarm snapshots; din1 also feeds the defrost delay selection
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      marker_position <= 2'h0;
      forwardedAlarm <= 2'h0;
    end
    else
    begin
      marker_position <= {din2, din1};
      if (monitorUpdate)
      begin
        forwardedAlarm <= {din2, din1};
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/tick_divider.sv
// One-cycle enable pulse every DIV system clocks.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module tick_divider
  import alarm_pkg::*;
#(
  parameter int DIV = 200000000
)
(
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_q;

  generate
    if (DIV < 1)
    begin : g_chk
      $error("tick_divider needs DIV of at least one");
    end
  endgenerate

  // Free-running count, pulse on wrap
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (count_q == LAST);
      count_q <= (count_q == LAST) ? '0 : count_q + 1'b1;
    end
  end
endmodule
`default_nettype wire
